// [hdl/dtc_timer.sv]
// What this block does
// - Timer function counts prescaled clock cycles
// - Prescale factor 1 to 16 from select
// - One prescaler shared by both timers
// - Compatibility defaults: divider 2, prescaler 6
// - Fast mode defaults: divider 0, prescaler 0
// - Counter function counts pin falling edges
// - Fast mode samples pin every cycle
// - New count visible cycle after detection
// - External count rate at most half clock
// - Compatibility samples pin per prescaler tick
// - Four modes; count-source and mode fields
// - Count-source bits at mode bits 6, 2
// - Mode 0: 13 bits, high plus low[4:0]
// - Mode 0 rollover sets overflow flag
// - Count only when run and gate allow
// - Setting run never clears the count
// - Mode 1: 16 bits, FFFF to 0 overflows
// - Mode 0 overflow after 8192 ticks
// - Mode 1 overflow after 65536 ticks
// - Timer 0 mirrors timer 1 with own bits
// - Flag set on overflow, cleared on vectoring
module dtc_timer #(
	parameter int NUM_TIMERS = 2
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic compat_mode,
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic count_input_pin_a,
	input wire logic count_input_pin_b,
	input wire logic gate_pin_a,
	input wire logic gate_pin_b,
	input wire logic [1:0] vector_ack,
	output logic overflow_flag_timer0,
	output logic overflow_flag_timer1
);
	logic [7:0] timer_control;
	logic [7:0] timer_mode;
	logic [7:0] timer_control_b;
	logic [3:0] timer_prescale_select;
	logic [2:0] clock_divider_select;
	logic [3:0] prescale_count;
	logic mode_seen;
	dtc_pkg::dtc_count_t count [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] pin_sample;
	logic [NUM_TIMERS-1:0] ovf_flag;

	wire logic apb_write = psel && penable && pwrite;
	wire logic [7:0] reg_addr = paddr[9:2];
	wire logic addr_ok = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0);
	wire logic hit_control = addr_ok && reg_addr == dtc_pkg::ADDR_CONTROL;
	wire logic hit_mode = addr_ok && reg_addr == dtc_pkg::ADDR_MODE;
	wire logic hit_control_b = addr_ok && reg_addr == dtc_pkg::ADDR_CONTROL_B;
	wire logic hit_clock = addr_ok && reg_addr == dtc_pkg::ADDR_CLOCK_CFG;
	wire logic hit_ack = addr_ok && reg_addr == dtc_pkg::ADDR_ACK;
	wire logic [NUM_TIMERS-1:0] hit_low;
	wire logic [NUM_TIMERS-1:0] hit_high;
	assign hit_low[0] = addr_ok && reg_addr == dtc_pkg::ADDR_T0_LOW;
	assign hit_low[1] = addr_ok && reg_addr == dtc_pkg::ADDR_T1_LOW;
	assign hit_high[0] = addr_ok && reg_addr == dtc_pkg::ADDR_T0_HIGH;
	assign hit_high[1] = addr_ok && reg_addr == dtc_pkg::ADDR_T1_HIGH;
	wire logic any_hit = hit_control | hit_mode | hit_control_b | hit_clock | hit_ack | (|hit_low) | (|hit_high);
	wire logic lane0 = apb_write && pstrb[0];

	// Shared prescaler tick: one pulse per (select+1) clocks
	wire logic tick = (prescale_count == timer_prescale_select);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_seen <= 1'b0;
			timer_prescale_select <= dtc_pkg::PRESCALE_FAST;
			clock_divider_select <= dtc_pkg::DIVIDER_FAST;
		end else if (!mode_seen) begin
			// Mode strap caught once after reset release
			mode_seen <= 1'b1;
			timer_prescale_select <= compat_mode ? dtc_pkg::PRESCALE_COMPAT : dtc_pkg::PRESCALE_FAST;
			clock_divider_select <= compat_mode ? dtc_pkg::DIVIDER_COMPAT : dtc_pkg::DIVIDER_FAST;
		end else if (lane0 && hit_clock) begin
			timer_prescale_select <= pwdata[3:0];
			clock_divider_select <= pwdata[6:4];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			prescale_count <= 4'h0;
		else if (tick)
			prescale_count <= 4'h0;
		else
			prescale_count <= prescale_count + 4'h1;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_mode <= dtc_pkg::RESET_MODE;
			timer_control_b <= dtc_pkg::RESET_CONTROL_B;
		end else begin
			if (lane0 && hit_mode)
				timer_mode <= pwdata[7:0];
			if (lane0 && hit_control_b)
				timer_control_b <= pwdata[7:0];
		end
	end

	wire logic [NUM_TIMERS-1:0] gate_pins = {gate_pin_b, gate_pin_a};
	wire logic [NUM_TIMERS-1:0] count_pins = {count_input_pin_b, count_input_pin_a};
	wire logic [NUM_TIMERS-1:0] run_bits = {timer_control[dtc_pkg::BIT_RUN1], timer_control[dtc_pkg::BIT_RUN0]};
	wire logic [NUM_TIMERS-1:0] overflow;

	generate
		for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
			dtc_pkg::dtc_tmode_t cfg;
			logic enable;
			logic fall;
			logic step;
			logic [15:0] cur;
			logic [15:0] inc16;
			logic [12:0] inc13;
			dtc_pkg::dtc_count_t next_count;
			assign cfg = timer_mode[4*i +: 4];
			assign enable = run_bits[i] && (!cfg.gate || gate_pins[i]);
			assign fall = tick && pin_sample[i] && !count_pins[i];
			assign step = enable && (cfg.counter_sel ? fall : tick);
			assign cur = count[i];
			assign inc16 = cur + 16'h0001;
			assign inc13 = {cur[15:8], cur[4:0]} + 13'h0001;
			// Higher modes not built here; they hold the count
			assign overflow[i] = step && ((cfg.mode == dtc_pkg::DTC_MODE_13BIT
				&& {cur[15:8], cur[4:0]} == dtc_pkg::MODE0_MAX)
				|| (cfg.mode == dtc_pkg::DTC_MODE_16BIT && cur == dtc_pkg::MODE1_MAX));

			always_comb begin
				next_count = count[i];
				if (step) begin
					unique case (cfg.mode)
						dtc_pkg::DTC_MODE_13BIT: next_count = {inc13[12:5], cur[7:5], inc13[4:0]};
						dtc_pkg::DTC_MODE_16BIT: next_count = inc16;
						dtc_pkg::DTC_MODE_RELOAD: next_count = count[i];
						dtc_pkg::DTC_MODE_SPLIT: next_count = count[i];
					endcase
				end
				// Software write wins over a same-cycle step
				if (lane0 && hit_low[i])
					next_count.low = pwdata[7:0];
				if (lane0 && hit_high[i])
					next_count.high = pwdata[7:0];
			end

			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					count[i] <= 16'h0000;
					pin_sample[i] <= 1'b1;
				end else begin
					count[i] <= next_count;
					if (tick)
						pin_sample[i] <= count_pins[i];
				end
			end

			// Set wins over both software and vector clears
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n)
					ovf_flag[i] <= 1'b0;
				else if (overflow[i])
					ovf_flag[i] <= 1'b1;
				else if (vector_ack[i] || (lane0 && hit_ack && pwdata[i]))
					ovf_flag[i] <= 1'b0;
				else if (lane0 && hit_control)
					ovf_flag[i] <= pwdata[i ? dtc_pkg::BIT_OVF1 : dtc_pkg::BIT_OVF0];
			end
		end
	endgenerate

	// Run and low edge bits; flags live in ovf_flag
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			timer_control <= dtc_pkg::RESET_CONTROL;
		else if (lane0 && hit_control)
			timer_control <= pwdata[7:0] & 8'h5f;
	end

	wire logic [7:0] control_view = {ovf_flag[1], timer_control[6], ovf_flag[0], timer_control[4:0]};
	logic [7:0] read_mux;
	always_comb begin
		read_mux = 8'h00;
		if (hit_control)
			read_mux = control_view;
		else if (hit_mode)
			read_mux = timer_mode;
		else if (hit_control_b)
			read_mux = timer_control_b;
		else if (hit_clock)
			read_mux = {1'b0, clock_divider_select, timer_prescale_select};
		else if (hit_low[0])
			read_mux = count[0].low;
		else if (hit_low[1])
			read_mux = count[1].low;
		else if (hit_high[0])
			read_mux = count[0].high;
		else if (hit_high[1])
			read_mux = count[1].high;
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !any_hit;
	assign prdata = {24'h000000, read_mux};
	assign overflow_flag_timer0 = ovf_flag[0];
	assign overflow_flag_timer1 = ovf_flag[1];
endmodule

// [common/dtc_pkg.sv]
package dtc_pkg;
	localparam logic [7:0] ADDR_CONTROL = 8'h88;
	localparam logic [7:0] ADDR_MODE = 8'h89;
	localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
	localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
	localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
	localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
	localparam logic [7:0] ADDR_CONTROL_B = 8'h91;
	localparam logic [7:0] ADDR_CLOCK_CFG = 8'h8e;
	localparam logic [7:0] ADDR_ACK = 8'h8f;
	localparam int BIT_OVF1 = 7;
	localparam int BIT_RUN1 = 6;
	localparam int BIT_OVF0 = 5;
	localparam int BIT_RUN0 = 4;
	localparam int BIT_GATING_ENABLE_TIMER1 = 7;
	localparam int BIT_CT1 = 6;
	localparam int BIT_GATING_ENABLE_TIMER0 = 3;
	localparam int BIT_CT0 = 2;
	localparam logic [7:0] RESET_CONTROL = 8'h00;
	localparam logic [7:0] RESET_MODE = 8'h00;
	localparam logic [7:0] RESET_CONTROL_B = 8'h00;
	localparam logic [3:0] PRESCALE_COMPAT = 4'h6;
	localparam logic [2:0] DIVIDER_COMPAT = 3'h2;
	localparam logic [3:0] PRESCALE_FAST = 4'h0;
	localparam logic [2:0] DIVIDER_FAST = 3'h0;
	localparam logic [12:0] MODE0_MAX = 13'h1fff;
	localparam logic [15:0] MODE1_MAX = 16'hffff;
	typedef enum logic [1:0] {
		DTC_MODE_13BIT,
		DTC_MODE_16BIT,
		DTC_MODE_RELOAD,
		DTC_MODE_SPLIT
	} dtc_mode_t;
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} dtc_count_t;
	typedef struct packed {
		logic gate;
		logic counter_sel;
		dtc_mode_t mode;
	} dtc_tmode_t;
endpackage

// [test/dtc_timer_properties.sv]
module dtc_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] vector_ack,
	input wire logic overflow_flag_timer0,
	input wire logic overflow_flag_timer1
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire logic wr_acc = psel && penable && pwrite;
	sequence acc_s; psel && penable; endsequence
	sequence rd_s; psel && penable && !pwrite; endsequence
	ready_now_a: assert property (acc_s |-> pready) else $error("no ready");
	rdata_upper_a: assert property (rd_s |-> prdata[31:8] == 24'h0) else $error("upper read bits");
	unmapped_err_a: assert property (acc_s and paddr == 32'h3fc |-> pslverr) else $error("no error");
	mapped_ok_a: assert property (acc_s and paddr == 32'h220 |-> !pslverr) else $error("bad error");
	flag0_hold_a: assert property (overflow_flag_timer0 && !vector_ack[0] && !wr_acc |=> overflow_flag_timer0)
		else $error("flag0 lost");
	flag1_hold_a: assert property (overflow_flag_timer1 && !vector_ack[1] && !wr_acc |=> overflow_flag_timer1)
		else $error("flag1 lost");
	flag0_clear_a: assert property ($fell(overflow_flag_timer0) |-> $past(vector_ack[0]) || $past(wr_acc))
		else $error("flag0 cleared alone");
	flag1_clear_a: assert property ($fell(overflow_flag_timer1) |-> $past(vector_ack[1]) || $past(wr_acc))
		else $error("flag1 cleared alone");
endmodule
bind dtc_timer dtc_checker u_chk (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .vector_ack, .overflow_flag_timer0, .overflow_flag_timer1);

// [test/dtc_pin_model.sv]
module dtc_pin_model #(
	parameter int HOLD = 2
) (
	input wire logic ref_clk,
	input wire logic [1:0] pin_run,
	input wire logic [1:0] gate_lvl,
	output logic count_input_pin_a,
	output logic count_input_pin_b,
	output logic gate_pin_a,
	output logic gate_pin_b
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] lvl = 2'h3;
	int cnt = 0;
	assign {count_input_pin_b, count_input_pin_a} = lvl;
	assign {gate_pin_b, gate_pin_a} = gate_lvl;
	always @(posedge ref_clk) begin
		cnt <= (cnt == HOLD - 1) ? 0 : cnt + 1;
		// Levels last HOLD clocks; idle pins float up high
		if (cnt == HOLD - 1) begin
			lvl <= (lvl ^ pin_run) | ~pin_run;
		end
	end
endmodule

// [test/tb_dual_timer_counter_modes01.sv]
module tb_dual_timer_counter_modes01;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, rst_n = 0, compat_mode = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic [31:0] paddr = '0, pwdata = '0, prdata;
	logic [3:0] pstrb = 4'hf;
	logic [1:0] vector_ack = '0, pin_run = '0, gate_lvl = 2'h3, fl;
	logic count_input_pin_a, count_input_pin_b, gate_pin_a, gate_pin_b, overflow_flag_timer0, overflow_flag_timer1;
	logic [7:0] rd;
	int err_count = 0, n_checks = 0, c;
	logic give_up = 1'b0;
	logic [39:0] rows [5] = '{40'h228a5, 40'h22c5a, 40'h2303c, 40'h234c3, 40'h24433};
	assign fl = {overflow_flag_timer1, overflow_flag_timer0};
	dtc_timer u_dut (.ref_clk, .rst_n, .compat_mode, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .count_input_pin_a, .count_input_pin_b, .gate_pin_a, .gate_pin_b, .vector_ack,
		.overflow_flag_timer0, .overflow_flag_timer1);
	dtc_pin_model u_pins (.ref_clk, .pin_run, .gate_lvl, .count_input_pin_a, .count_input_pin_b, .gate_pin_a,
		.gate_pin_b);
	initial forever #5 ref_clk = ~ref_clk;
	function automatic logic [31:0] ra(input logic [7:0] o);
		return {22'h0, o, 2'b00};
	endfunction
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic [31:0] a, input logic w, input logic [7:0] d);
		int i;
		psel <= 1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		rd = prdata[7:0];
		er = pslverr;
		chk("ready", pready, 1);
		if (pready !== 1'b1)
			give_up = 1'b1;
		psel <= 0;
		penable <= 0;
		// Idle edge so psel is never driven twice in one step
		@(posedge ref_clk);
	endtask
	task automatic wait_flag(input int i, input int lim);
		for (c = 0; fl[i] !== 1'b1 && c < lim; c++)
			@(negedge ref_clk);
		chk("flag wait", c < lim, 1);
		if (c >= lim)
			give_up = 1'b1;
		@(posedge ref_clk);
	endtask
	task automatic do_reset(input logic cm, input logic [7:0] cfg);
		rst_n <= 0;
		compat_mode <= cm;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1;
		repeat (2) @(posedge ref_clk);
		chk("flags", fl, 0);
		apb(ra(dtc_pkg::ADDR_CLOCK_CFG), 0, 0);
		chk("clock cfg", rd, cfg);
	endtask
	initial begin
		do_reset(1, 8'h26);
		do_reset(0, 8'h00);
		foreach (rows[k]) begin
			apb(rows[k][39:8], 1, rows[k][7:0]);
			apb(rows[k][39:8], 0, 0);
			chk("count reg", rd, rows[k][7:0]);
		end
		apb(32'h3fc, 0, 0);
		chk("unmapped", er, 1);
		// Prescale 4, 16 ticks from fff0 to rollover
		apb(ra(dtc_pkg::ADDR_CLOCK_CFG), 1, 8'h03);
		apb(ra(dtc_pkg::ADDR_MODE), 1, 8'h01);
		apb(ra(dtc_pkg::ADDR_T0_HIGH), 1, 8'hff);
		apb(ra(dtc_pkg::ADDR_T0_LOW), 1, 8'hf0);
		apb(ra(dtc_pkg::ADDR_CONTROL), 1, 8'h10);
		wait_flag(0, 200);
		chk("t0 ovf time", c inside {[58:66]}, 1);
		vector_ack <= 2'h1;
		@(posedge ref_clk);
		vector_ack <= 2'h0;
		repeat (2) @(posedge ref_clk);
		chk("t0 ack", fl[0], 0);
		apb(ra(dtc_pkg::ADDR_CONTROL), 1, 8'h00);
		// Timer 1 counts pin edges, 13 bits, gated
		apb(ra(dtc_pkg::ADDR_CLOCK_CFG), 1, 8'h00);
		apb(ra(dtc_pkg::ADDR_MODE), 1, 8'hc0);
		apb(ra(dtc_pkg::ADDR_T1_HIGH), 1, 8'hff);
		apb(ra(dtc_pkg::ADDR_T1_LOW), 1, 8'hfe);
		gate_lvl <= 2'h1;
		pin_run <= 2'h2;
		apb(ra(dtc_pkg::ADDR_CONTROL), 1, 8'h40);
		repeat (30) @(posedge ref_clk);
		apb(ra(dtc_pkg::ADDR_T1_LOW), 0, 0);
		chk("gated low", rd & 8'h1f, 8'h1e);
		gate_lvl <= 2'h3;
		wait_flag(1, 40);
		chk("t1 ovf", fl[1], 1);
		pin_run <= 2'h0;
		apb(ra(dtc_pkg::ADDR_T1_HIGH), 0, 0);
		chk("t1 high", rd, 8'h00);
		apb(ra(dtc_pkg::ADDR_T1_LOW), 0, 0);
		chk("t1 low top", rd & 8'he0, 8'he0);
		apb(ra(dtc_pkg::ADDR_ACK), 1, 8'h02);
		chk("t1 ack reg", fl[1], 0);
		pstrb <= 4'he;
		apb(ra(dtc_pkg::ADDR_MODE), 1, 8'h33);
		pstrb <= 4'hf;
		apb(ra(dtc_pkg::ADDR_MODE), 0, 0);
		chk("strobe off", rd, 8'hc0);
		tally_and_finish();
	end
	initial begin
		for (int k = 0; k < 20000 && !give_up; k++)
			@(posedge ref_clk);
		err_count++;
		tally_and_finish();
	end
endmodule
